//--- hw/coag_core.sv
// Operand fetch and effective-address generation for an 8-bit CPU
// Assumes single-cycle combinational memory read on the internal bus
module coag_core #(
  parameter logic [15:0] PC_INIT = coag_pkg::PC_RESET
) (
  // Clock, reset, enable
  input  wire logic               clk,
  input  wire logic               nrst,
  input  wire logic               ce,
  // Memory bus
  output logic [15:0]             mem_addr,
  output logic                    mem_rd,
  output logic                    mem_wr,
  output logic [7:0]              mem_wdata,
  input  wire logic [7:0]         mem_rdata,
  // Interrupt pin
  input  wire logic               irq_n,
  // Programmer-visible state
  output logic [7:0]              acc,
  output logic [7:0]              idx,
  output logic [15:0]             pc,
  output logic                    carry,
  output logic                    zero,
  output logic                    irq_enable,
  output logic                    osc_halt,
  output logic                    cpu_wait,
  // Completion report
  output logic                    exec_valid,
  output logic [7:0]              exec_opcode,
  output coag_pkg::coag_mode_t    exec_mode,
  output logic [15:0]             exec_ea,
  output logic [7:0]              exec_data,
  output logic                    bad_opcode
);
  ////////////////////////////////////////////////////////////////////////
  // Datapath functions
  function automatic logic [8:0] alu_f(input logic [3:0] lo,
                                       input logic [7:0] a,
                                       input logic [7:0] m,
                                       input logic c);
    unique case (lo)
      coag_pkg::LO_SUB, coag_pkg::LO_CMP,
      coag_pkg::LO_CPX: alu_f = {1'b0, a} - {1'b0, m};
      coag_pkg::LO_SBC: alu_f = {1'b0, a} - {1'b0, m} - {8'h00, c};
      coag_pkg::LO_AND,
      coag_pkg::LO_BIT: alu_f = {c, a & m};
      coag_pkg::LO_EOR: alu_f = {c, a ^ m};
      coag_pkg::LO_ADC: alu_f = {1'b0, a} + {1'b0, m} + {8'h00, c};
      coag_pkg::LO_ORA: alu_f = {c, a | m};
      coag_pkg::LO_ADD: alu_f = {1'b0, a} + {1'b0, m};
      default:          alu_f = {c, m};
    endcase
  endfunction

  function automatic logic [8:0] rmw_f(input logic [3:0] lo,
                                       input logic [7:0] v,
                                       input logic c);
    unique case (lo)
      coag_pkg::LO_NEG: rmw_f = {v != 8'h00, 8'h00 - v};
      coag_pkg::LO_COM: rmw_f = {1'b1, ~v};
      coag_pkg::LO_LSR: rmw_f = {v[0], 1'b0, v[7:1]};
      coag_pkg::LO_ROR: rmw_f = {v[0], c, v[7:1]};
      coag_pkg::LO_ASR: rmw_f = {v[0], v[7], v[7:1]};
      coag_pkg::LO_LSL: rmw_f = {v[7], v[6:0], 1'b0};
      coag_pkg::LO_ROL: rmw_f = {v[7], v[6:0], c};
      coag_pkg::LO_DEC: rmw_f = {c, v - 8'h01};
      coag_pkg::LO_INC: rmw_f = {c, v + 8'h01};
      coag_pkg::LO_CLR: rmw_f = {c, 8'h00};
      default:          rmw_f = {c, v};
    endcase
  endfunction

  function automatic logic [7:0] ea_bit_f(input logic [7:0] v,
                                          input logic [2:0] n,
                                          input logic s);
    ea_bit_f    = v;
    ea_bit_f[n] = s;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Reset release and pin synchroniser
  logic rst_q1;
  logic rst_n;
  logic irq_q1;
  logic irq_q2;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_q1 <= 1'b0;
      rst_n  <= 1'b0;
    end
    else
    begin
      rst_q1 <= 1'b1;
      rst_n  <= rst_q1;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_q1 <= 1'b1;
      irq_q2 <= 1'b1;
    end
    else if (ce)
    begin
      irq_q1 <= irq_n;
      irq_q2 <= irq_q1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Decode
  coag_pkg::coag_state_t state;
  coag_pkg::coag_state_t next_state;
  coag_pkg::coag_mode_t  mode;
  coag_pkg::coag_cls_t   cls;
  logic [7:0]  opcode;
  logic [7:0]  addr_hi;
  logic [15:0] ea;
  logic [7:0]  wb_data;
  logic        imask;
  logic        legal;
  logic        br_hit_q;

  wire logic       in_fetch = (state == coag_pkg::st_fetch);
  wire logic [7:0] cur_op   = in_fetch ? mem_rdata : opcode;
  wire logic [3:0] lo       = cur_op[3:0];
  wire logic [2:0] bit_n    = cur_op[3:1];

  coag_decode u_decode (
    .opcode (cur_op),
    .mode   (mode),
    .cls    (cls),
    .legal  (legal)
  );

  wire logic is_store = (cls == coag_pkg::cls_store_a) ||
                        (cls == coag_pkg::cls_store_x);
  wire logic is_jump  = (cls == coag_pkg::cls_jmp) ||
                        (cls == coag_pkg::cls_jsr);
  wire logic rmw_wb   = ((cls == coag_pkg::cls_rmw) &&
                         (lo != coag_pkg::LO_TST)) ||
                        (cls == coag_pkg::cls_bitsc);

  ////////////////////////////////////////////////////////////////////////
  // Bus drive
  wire logic pc_cycle = (state == coag_pkg::st_fetch) ||
                        (state == coag_pkg::st_imm) ||
                        (state == coag_pkg::st_addr_hi) ||
                        (state == coag_pkg::st_addr_lo) ||
                        (state == coag_pkg::st_rel);
  wire logic op_cycle = (state == coag_pkg::st_operand);
  wire logic ea_read  = op_cycle && !is_store && !is_jump;
  wire logic ea_write = (op_cycle && is_store) ||
                        (state == coag_pkg::st_write);
  // Bus idle while frozen or until reset is released
  wire logic bus_on   = ce && rst_n;

  assign mem_rd    = bus_on && (pc_cycle || ea_read);
  assign mem_wr    = bus_on && ea_write;
  assign mem_addr  = pc_cycle ? pc : ea;
  assign mem_wdata = (cls == coag_pkg::cls_store_a) ? acc :
                     (cls == coag_pkg::cls_store_x) ? idx : wb_data;

  ////////////////////////////////////////////////////////////////////////
  // Operand results
  wire logic [8:0] alu_res = alu_f(lo,
                                   (cls == coag_pkg::cls_cpx) ? idx : acc,
                                   mem_rdata, carry);
  wire logic [8:0] rmw_mem = rmw_f(lo, mem_rdata, carry);
  wire logic       inh_x   = (cur_op[7:4] == coag_pkg::COL_INH_X);
  wire logic [8:0] rmw_reg = rmw_f(lo, inh_x ? idx : acc, carry);
  wire logic [7:0] bit_sc  = ea_bit_f(mem_rdata, bit_n, ~cur_op[0]);
  wire logic       br_hit  = (mem_rdata[bit_n] == ~cur_op[0]);
  wire logic [15:0] br_tgt = pc + 16'h0001 + {{8{mem_rdata[7]}}, mem_rdata};
  wire logic [15:0] mul_p  = {8'h00, acc} * {8'h00, idx};
  wire logic       wakeup  = !irq_q2 && !imask;

  ////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_comb
  begin
    next_state = state;
    unique case (state)
      coag_pkg::st_fetch:
        if (legal)
          unique case (mode)
            coag_pkg::mode_inh: next_state = coag_pkg::st_inh1;
            coag_pkg::mode_imm: next_state = coag_pkg::st_imm;
            coag_pkg::mode_ext: next_state = coag_pkg::st_addr_hi;
            coag_pkg::mode_dir: next_state = coag_pkg::st_addr_lo;
            coag_pkg::mode_ix:  next_state = coag_pkg::st_index;
            default:            next_state = coag_pkg::st_fetch;
          endcase
      coag_pkg::st_addr_hi: next_state = coag_pkg::st_addr_lo;
      coag_pkg::st_addr_lo,
      coag_pkg::st_index:   next_state = coag_pkg::st_operand;
      coag_pkg::st_operand:
        next_state = rmw_wb ? coag_pkg::st_write :
                     (cls == coag_pkg::cls_brbit) ? coag_pkg::st_rel :
                     coag_pkg::st_fetch;
      coag_pkg::st_inh1:    next_state = coag_pkg::st_inh2;
      coag_pkg::st_inh2:
        next_state = (opcode == coag_pkg::OP_STOP ||
                      opcode == coag_pkg::OP_WAIT) ? coag_pkg::st_halt
                                                   : coag_pkg::st_fetch;
      coag_pkg::st_halt:
        next_state = wakeup ? coag_pkg::st_fetch : coag_pkg::st_halt;
      default:              next_state = coag_pkg::st_fetch;
    endcase
  end

  wire logic done = (next_state == coag_pkg::st_fetch) && !in_fetch &&
                    (state != coag_pkg::st_halt);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state <= coag_pkg::st_fetch;
    else if (ce)
      state <= next_state;
  end

  // Program counter steps on every byte read at it
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pc <= PC_INIT;
    else if (ce)
    begin
      if (op_cycle && is_jump)
        pc <= ea;
      else if (state == coag_pkg::st_rel && br_hit_q)
        pc <= br_tgt;
      else if (pc_cycle)
        pc <= pc + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Address formation
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      opcode   <= 8'h00;
      addr_hi  <= coag_pkg::PAGE0_HI;
      ea       <= 16'h0000;
      wb_data  <= 8'h00;
      br_hit_q <= 1'b0;
    end
    else if (ce)
    begin
      if (in_fetch)
      begin
        opcode  <= mem_rdata;
        addr_hi <= coag_pkg::PAGE0_HI;
      end
      if (state == coag_pkg::st_addr_hi)
        addr_hi <= mem_rdata;
      if (state == coag_pkg::st_addr_lo)
        ea <= {addr_hi, mem_rdata};
      if (state == coag_pkg::st_index)
        ea <= {coag_pkg::PAGE0_HI, idx + coag_pkg::NO_OFFSET};
      if (op_cycle)
      begin
        wb_data  <= (cls == coag_pkg::cls_bitsc) ? bit_sc : rmw_mem[7:0];
        br_hit_q <= br_hit;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers and flags
  wire logic mem_data = (state == coag_pkg::st_imm) || ea_read;
  wire logic alu_wr   = (lo != coag_pkg::LO_CMP) && (lo != coag_pkg::LO_BIT);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acc   <= 8'h00;
      idx   <= 8'h00;
      carry <= 1'b0;
      zero  <= 1'b0;
      imask <= 1'b1;
    end
    else if (ce)
    begin
      if (mem_data)
        unique case (cls)
          coag_pkg::cls_load_a: acc <= mem_rdata;
          coag_pkg::cls_load_x: idx <= mem_rdata;
          coag_pkg::cls_alu:
          begin
            if (alu_wr)
              acc <= alu_res[7:0];
            carry <= alu_res[8];
            zero  <= (alu_res[7:0] == 8'h00);
          end
          coag_pkg::cls_cpx:
          begin
            carry <= alu_res[8];
            zero  <= (alu_res[7:0] == 8'h00);
          end
          coag_pkg::cls_rmw:
          begin
            carry <= rmw_mem[8];
            zero  <= (rmw_mem[7:0] == 8'h00);
          end
          default:
            zero <= zero;
        endcase
      if (state == coag_pkg::st_inh2)
      begin
        if (opcode == coag_pkg::OP_MUL)
          {idx, acc} <= mul_p;
        else if (opcode == coag_pkg::OP_TAX)
          idx <= acc;
        else if (opcode == coag_pkg::OP_TXA)
          acc <= idx;
        else if (opcode == coag_pkg::OP_CLC || opcode == coag_pkg::OP_SEC)
          carry <= opcode[0];
        else if (opcode == coag_pkg::OP_CLI || opcode == coag_pkg::OP_SEI)
          imask <= opcode[0];
        else if (opcode == coag_pkg::OP_STOP || opcode == coag_pkg::OP_WAIT)
          imask <= 1'b0;
        else if (opcode[7:4] == coag_pkg::COL_INH_A ||
                 opcode[7:4] == coag_pkg::COL_INH_X)
        begin
          if (inh_x)
            idx <= rmw_reg[7:0];
          else if (lo != coag_pkg::LO_TST)
            acc <= rmw_reg[7:0];
          carry <= rmw_reg[8];
          zero  <= (rmw_reg[7:0] == 8'h00);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Low-power state and completion report
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      osc_halt    <= 1'b0;
      cpu_wait    <= 1'b0;
      exec_valid  <= 1'b0;
      bad_opcode  <= 1'b0;
      exec_opcode <= 8'h00;
      exec_mode   <= coag_pkg::mode_none;
      exec_ea     <= 16'h0000;
      exec_data   <= 8'h00;
    end
    else if (ce)
    begin
      if (state == coag_pkg::st_inh2)
      begin
        osc_halt <= (opcode == coag_pkg::OP_STOP);
        cpu_wait <= (opcode == coag_pkg::OP_WAIT);
      end
      else if (state == coag_pkg::st_halt && wakeup)
      begin
        osc_halt <= 1'b0;
        cpu_wait <= 1'b0;
      end
      exec_valid <= done;
      bad_opcode <= in_fetch && !legal;
      if (done)
      begin
        exec_opcode <= opcode;
        exec_mode   <= mode;
        exec_ea     <= ea;
      end
      if (mem_data)
        exec_data <= mem_rdata;
    end
  end

  assign irq_enable = !imask;
endmodule

//--- hw/coag_pkg.sv
// Constants, opcode map and types for the operand address generator
// Assumes a byte-wide memory bus and a 16-bit address space
package coag_pkg;
  localparam int DW = 8;
  localparam int AW = 16;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] PAGE0_HI = 8'h00;
  localparam logic [7:0] NO_OFFSET = 8'h00;

  ////////////////////////////////////////////////////////////////////////
  // Opcode columns (high nibble)
  localparam logic [3:0] COL_BRBIT = 4'h0;
  localparam logic [3:0] COL_BITSC = 4'h1;
  localparam logic [3:0] COL_RMW_D = 4'h3;
  localparam logic [3:0] COL_INH_A = 4'h4;
  localparam logic [3:0] COL_INH_X = 4'h5;
  localparam logic [3:0] COL_RMW_X = 4'h7;
  localparam logic [3:0] COL_CTL8  = 4'h8;
  localparam logic [3:0] COL_CTL9  = 4'h9;
  localparam logic [3:0] COL_IMM   = 4'ha;
  localparam logic [3:0] COL_DIR   = 4'hb;
  localparam logic [3:0] COL_EXT   = 4'hc;
  localparam logic [3:0] COL_IX    = 4'hf;

  // Legal low nibbles per column group
  localparam logic [15:0] MASK_RMW  = 16'hb7d9;
  localparam logic [15:0] MASK_IMM  = 16'h4f7f;
  localparam logic [15:0] MASK_CTL8 = 16'hc00b;
  localparam logic [15:0] MASK_CTL9 = 16'hbf80;

  // Register/memory column low nibbles
  localparam logic [3:0] LO_SUB = 4'h0;
  localparam logic [3:0] LO_CMP = 4'h1;
  localparam logic [3:0] LO_SBC = 4'h2;
  localparam logic [3:0] LO_CPX = 4'h3;
  localparam logic [3:0] LO_AND = 4'h4;
  localparam logic [3:0] LO_BIT = 4'h5;
  localparam logic [3:0] LO_LOAD_A = 4'h6;
  localparam logic [3:0] LO_STA = 4'h7;
  localparam logic [3:0] LO_EOR = 4'h8;
  localparam logic [3:0] LO_ADC = 4'h9;
  localparam logic [3:0] LO_ORA = 4'ha;
  localparam logic [3:0] LO_ADD = 4'hb;
  localparam logic [3:0] LO_JMP = 4'hc;
  localparam logic [3:0] LO_JSR = 4'hd;
  localparam logic [3:0] LO_LDX = 4'he;
  localparam logic [3:0] LO_STX = 4'hf;

  // Read-modify-write low nibbles
  localparam logic [3:0] LO_NEG = 4'h0;
  localparam logic [3:0] LO_COM = 4'h3;
  localparam logic [3:0] LO_LSR = 4'h4;
  localparam logic [3:0] LO_ROR = 4'h6;
  localparam logic [3:0] LO_ASR = 4'h7;
  localparam logic [3:0] LO_LSL = 4'h8;
  localparam logic [3:0] LO_ROL = 4'h9;
  localparam logic [3:0] LO_DEC = 4'ha;
  localparam logic [3:0] LO_INC = 4'hc;
  localparam logic [3:0] LO_TST = 4'hd;
  localparam logic [3:0] LO_CLR = 4'hf;

  // Inherent control opcodes
  localparam logic [7:0] OP_MUL  = 8'h42;
  localparam logic [7:0] OP_STOP = 8'h8e;
  localparam logic [7:0] OP_WAIT = 8'h8f;
  localparam logic [7:0] OP_TAX  = 8'h97;
  localparam logic [7:0] OP_CLC  = 8'h98;
  localparam logic [7:0] OP_SEC  = 8'h99;
  localparam logic [7:0] OP_CLI  = 8'h9a;
  localparam logic [7:0] OP_SEI  = 8'h9b;
  localparam logic [7:0] OP_TXA  = 8'h9f;

  typedef enum logic [2:0] {
    mode_inh, mode_imm, mode_dir, mode_ext, mode_ix, mode_none
  } coag_mode_t;

  typedef enum logic [3:0] {
    cls_load_a, cls_load_x, cls_store_a, cls_store_x, cls_alu, cls_cpx,
    cls_jmp, cls_jsr, cls_rmw, cls_bitsc, cls_brbit, cls_inh
  } coag_cls_t;

  typedef enum logic [3:0] {
    st_fetch, st_imm, st_addr_hi, st_addr_lo, st_index, st_operand,
    st_write, st_rel, st_inh1, st_inh2, st_halt
  } coag_state_t;
endpackage

//--- hw/coag_decode.sv
// Opcode decoder: addressing mode, operation class and legality
// Assumes the opcode is stable for the whole cycle it is read
module coag_decode (
  // Opcode
  input  wire logic [7:0]         opcode,
  // Decoded fields
  output coag_pkg::coag_mode_t    mode,
  output coag_pkg::coag_cls_t     cls,
  output logic                    legal
);
  function automatic coag_pkg::coag_cls_t col_cls(input logic [3:0] lo);
    unique case (lo)
      coag_pkg::LO_LOAD_A: col_cls = coag_pkg::cls_load_a;
      coag_pkg::LO_LDX: col_cls = coag_pkg::cls_load_x;
      coag_pkg::LO_STA: col_cls = coag_pkg::cls_store_a;
      coag_pkg::LO_STX: col_cls = coag_pkg::cls_store_x;
      coag_pkg::LO_CPX: col_cls = coag_pkg::cls_cpx;
      coag_pkg::LO_JMP: col_cls = coag_pkg::cls_jmp;
      coag_pkg::LO_JSR: col_cls = coag_pkg::cls_jsr;
      default:          col_cls = coag_pkg::cls_alu;
    endcase
  endfunction

  wire logic [3:0] hi = opcode[7:4];
  wire logic [3:0] lo = opcode[3:0];
  // Immediate: no stores, jumps or subroutine calls
  wire logic is_imm   = (hi == coag_pkg::COL_IMM) &&
                        coag_pkg::MASK_IMM[lo];
  wire logic is_ext   = (hi == coag_pkg::COL_EXT);
  wire logic is_dcol  = (hi == coag_pkg::COL_DIR);
  wire logic is_xcol  = (hi == coag_pkg::COL_IX);
  wire logic rmw_ok   = coag_pkg::MASK_RMW[lo];
  wire logic rmw_d    = (hi == coag_pkg::COL_RMW_D) && rmw_ok;
  wire logic rmw_x    = (hi == coag_pkg::COL_RMW_X) && rmw_ok;
  wire logic is_bsc   = (hi == coag_pkg::COL_BITSC);
  wire logic is_brb   = (hi == coag_pkg::COL_BRBIT);
  // Direct: all extended operations plus memory RMW and bit ops
  wire logic is_dir   = is_dcol || rmw_d || is_bsc || is_brb;
  // Indexed no offset: direct set minus bit operations
  wire logic is_ix    = is_xcol || rmw_x;
  wire logic inh_ax   = ((hi == coag_pkg::COL_INH_A) ||
                         (hi == coag_pkg::COL_INH_X)) && rmw_ok;
  wire logic inh_ctl  = (opcode == coag_pkg::OP_MUL) ||
                        ((hi == coag_pkg::COL_CTL8) &&
                         coag_pkg::MASK_CTL8[lo]) ||
                        ((hi == coag_pkg::COL_CTL9) &&
                         coag_pkg::MASK_CTL9[lo]);
  wire logic is_inh   = inh_ax || inh_ctl;

  assign legal = is_inh || is_imm || is_ext || is_dir || is_ix;
  assign mode  = is_inh ? coag_pkg::mode_inh :
                 is_imm ? coag_pkg::mode_imm :
                 is_ext ? coag_pkg::mode_ext :
                 is_dir ? coag_pkg::mode_dir :
                 is_ix  ? coag_pkg::mode_ix  : coag_pkg::mode_none;
  assign cls   = is_inh             ? coag_pkg::cls_inh   :
                 is_brb             ? coag_pkg::cls_brbit :
                 is_bsc             ? coag_pkg::cls_bitsc :
                 (rmw_d || rmw_x)   ? coag_pkg::cls_rmw   : col_cls(lo);
endmodule

//--- tb/coag_mem_model.sv
// Byte-wide memory on the internal bus, answers reads in the same cycle
// Assumes the bench preloads mem by hierarchical reference
module coag_mem_model (
  // Clock
  input  wire logic        clk,
  // Bus
  input  wire logic [15:0] addr,
  input  wire logic        rd,
  input  wire logic        wr,
  input  wire logic [7:0]  wdata,
  output logic [7:0]       rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:65535];

  // Unselected: inverse data so a stale byte is never mistaken for valid
  assign rdata = rd ? mem[addr] : ~mem[addr];

  always @(posedge clk)
  begin
    if (wr)
      mem[addr] <= wdata;
  end
endmodule

//--- tb/coag_core_assertions.sv
// Port checks for the operand address generator core
// Assumes bind onto coag_core; sees only its ports
module coag_core_assertions (
  // Clock and reset
  input logic                 clk,
  input logic                 nrst,
  // Bus and state
  input logic [15:0]          mem_addr,
  input logic                 mem_rd,
  input logic                 mem_wr,
  input logic [7:0]           mem_rdata,
  input logic [7:0]           acc,
  input logic [7:0]           idx,
  input logic                 osc_halt,
  input logic                 cpu_wait,
  // Completion report
  input logic                 exec_valid,
  input logic [7:0]           exec_opcode,
  input coag_pkg::coag_mode_t exec_mode,
  input logic [15:0]          exec_ea
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  sequence s_load_end;
    exec_valid && exec_opcode inside {8'hc6, 8'hb6, 8'hf6};
  endsequence
  sequence s_ext_end;
    exec_valid && exec_opcode == 8'hc6;
  endsequence
  property p_load_read;
    s_load_end |-> $past(mem_rd) && $past(mem_addr) == exec_ea
      && acc == $past(mem_rdata);
  endproperty
  property p_ext_addr;
    s_ext_end |-> exec_ea == {$past(mem_rdata, 3), $past(mem_rdata, 2)}
      && $past(mem_addr, 2) == $past(mem_addr, 4) + 16'h2;
  endproperty
  property p_dir_addr;
    exec_valid && exec_opcode == 8'hb6 |->
      exec_ea == {8'h00, $past(mem_rdata, 2)};
  endproperty
  property p_dir_page;
    exec_valid && exec_mode == coag_pkg::mode_dir |-> exec_ea[15:8] == 8'h00;
  endproperty
  property p_ix_addr;
    exec_valid && exec_opcode == 8'hf6 |->
      exec_ea == {8'h00, idx} && !$past(mem_rd, 2);
  endproperty
  property p_imm_load;
    exec_valid && exec_opcode == 8'ha6 |-> acc == $past(mem_rdata)
      && $past(mem_addr) == $past(mem_addr, 2) + 16'h1;
  endproperty
  property p_imm_next;
    exec_valid && exec_mode == coag_pkg::mode_imm |->
      mem_rd && mem_addr == $past(mem_addr, 2) + 16'h2;
  endproperty
  property p_inh_len;
    exec_valid && exec_opcode == 8'h4c |-> mem_rd && !$past(mem_rd)
      && mem_addr == $past(mem_addr, 3) + 16'h1;
  endproperty
  property p_halt_quiet;
    osc_halt || cpu_wait |-> !mem_rd && !mem_wr;
  endproperty

  a_load_read: assert property (p_load_read)
    else $error("load did not read its effective address");
  a_ext_addr: assert property (p_ext_addr)
    else $error("extended address not high then low byte");
  a_dir_addr: assert property (p_dir_addr)
    else $error("direct address not from operand byte");
  a_dir_page: assert property (p_dir_page)
    else $error("direct address outside page zero");
  a_ix_addr: assert property (p_ix_addr)
    else $error("indexed address not the index register");
  a_imm_load: assert property (p_imm_load)
    else $error("immediate load took the wrong byte");
  a_imm_next: assert property (p_imm_next)
    else $error("immediate instruction length wrong");
  a_inh_len: assert property (p_inh_len)
    else $error("inherent instruction not one byte");
  a_halt_quiet: assert property (p_halt_quiet)
    else $error("bus active while halted");
endmodule

bind coag_core coag_core_assertions chk (
  .clk, .nrst, .mem_addr, .mem_rd, .mem_wr, .mem_rdata, .acc, .idx,
  .osc_halt, .cpu_wait, .exec_valid, .exec_opcode, .exec_mode, .exec_ea
);

//--- tb/coag_core_tb_top.sv
// Random program bench for the operand address generator core
// Assumes program at 8000 and a known pattern everywhere else
module coag_core_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, nrst, ce, irq_n, mem_rd, mem_wr;
  logic        exec_valid, bad_opcode, cpu_wait;
  logic [7:0]  mem_wdata, mem_rdata, acc, exec_opcode, a, d;
  logic [15:0] mem_addr, exec_ea, ad, wp;
  logic [7:0]  e_op [128];
  logic [7:0]  e_acc [128];
  logic [15:0] e_ea [128];
  logic [15:0] e_na [128];
  integer      seed;
  int          bad_count, n_tests, n, i, w;

  coag_core #(.PC_INIT(16'h8000)) uut (
    .clk, .nrst, .ce, .mem_addr, .mem_rd, .mem_wr, .mem_wdata,
    .mem_rdata, .irq_n, .acc, .idx(), .pc(), .carry(), .zero(),
    .irq_enable(), .osc_halt(), .cpu_wait, .exec_valid,
    .exec_opcode, .exec_mode(), .exec_ea, .exec_data(), .bad_opcode
  );
  coag_mem_model mem_i (
    .clk, .addr(mem_addr), .rd(mem_rd), .wr(mem_wr), .wdata(mem_wdata),
    .rdata(mem_rdata)
  );

  //////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] pat(input logic [15:0] v);
    return v[7:0] ^ v[15:8] ^ 8'h3c;
  endfunction

  task ins(input logic [7:0] o, input logic [15:0] ops, input int len,
           input logic [15:0] ea);
    mem_i.mem[wp] = o;
    if (len == 3)
      mem_i.mem[wp + 16'h1] = ops[15:8];
    if (len > 1)
      mem_i.mem[wp + 16'(len - 1)] = ops[7:0];
    wp = wp + 16'(len);
    e_op[n] = o;
    e_ea[n] = ea;
    e_acc[n] = a;
    e_na[n] = wp;
    n++;
  endtask

  task chk(input string s, input logic [15:0] ex, input logic [15:0] got);
    n_tests++;
    if (got !== ex)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", s, ex, got);
    end
  endtask

  task stop_test;
    $display("checks %0d errors %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end

  initial
  begin
    seed = 32'h16ff;
    {bad_count, n_tests, n} = 0;
    {nrst, ce, irq_n} = 3'b011;
    for (i = 0; i < 65536; i++)
      mem_i.mem[i] = pat(16'(i));
    wp = 16'h8000;
    a = 8'h00;
    for (i = 0; i < 40; i++)
    begin
      d = 8'($random(seed));
      ad = 16'($random(seed)) & 16'h7fff;
      case ($random(seed) & 3)
        0:
        begin
          a = d;
          ins(8'ha6, {8'h00, d}, 2, 16'h0);
          a = a + 8'h1;
          ins(8'h4c, 16'h0, 1, 16'h0);
        end
        1:
        begin
          a = pat(ad);
          ins(8'hc6, ad, 3, ad);
        end
        2:
        begin
          a = pat({8'h00, d});
          ins(8'hb6, {8'h00, d}, 2, {8'h00, d});
        end
        default:
        begin
          ins(8'hae, {8'h00, d}, 2, 16'h0);
          a = pat({8'h00, d});
          ins(8'hf6, 16'h0, 1, {8'h00, d});
        end
      endcase
    end
    ins(8'hb7, {8'h00, d}, 2, {8'h00, d});
    mem_i.mem[wp] = 8'ha7;
    mem_i.mem[wp + 16'h1] = 8'h8f;
    repeat (20) @(negedge clk);
    nrst = 1;
    for (i = 0; i < n; i++)
    begin
      for (w = 0; exec_valid !== 1'b1 && w < 40; w++)
        @(negedge clk);
      if (w == 40)
      begin
        bad_count++;
        stop_test;
      end
      chk("opcode", {8'h00, e_op[i]}, {8'h00, exec_opcode});
      chk("acc", {8'h00, e_acc[i]}, {8'h00, acc});
      chk("next fetch", e_na[i], mem_addr);
      if (e_op[i] inside {8'hb6, 8'hc6, 8'hf6, 8'hb7})
        chk("ea", e_ea[i], exec_ea);
      @(negedge clk);
    end
    for (w = 0; bad_opcode !== 1'b1 && w < 10; w++)
      @(negedge clk);
    chk("bad opcode", 16'h1, {15'h0, bad_opcode});
    chk("store", {8'h00, a}, {8'h00, mem_i.mem[{8'h00, d}]});
    for (w = 0; cpu_wait !== 1'b1 && w < 10; w++)
      @(negedge clk);
    chk("wait", 16'h1, {15'h0, cpu_wait});
    chk("wait bus", 16'h0, {14'h0, mem_rd, mem_wr});
    irq_n = 0;
    for (w = 0; cpu_wait !== 1'b0 && w < 10; w++)
      @(negedge clk);
    chk("wake", 16'h0, {15'h0, cpu_wait});
    chk("resume", wp + 16'h2, mem_addr);
    stop_test;
  end
endmodule
